// file: xpes_pkg.sv
package xpes_pkg;
  // on-chip bus word addresses of the emulation registers
  localparam logic [15:0] ADDR_EMU_SCRATCH_ZERO  = 16'heb76;
  localparam logic [15:0] ADDR_EMU_SCRATCH_ONE   = 16'heb78;
  localparam logic [15:0] ADDR_EMU_SCRATCH_TWO   = 16'heb7a;
  localparam logic [15:0] ADDR_EMU_SCRATCH_THREE = 16'heb7c;
  localparam logic [15:0] ADDR_EMU_COPY          = 16'heb7e;
  // peripheral enable word layout
  localparam logic [15:0] PEW_IMPL_MASK  = 16'h07df;
  localparam logic [15:0] PEW_RESET      = 16'h0005;
  localparam logic [15:0] PEW_PERIPH_MSK = 16'h07d3;
  localparam int FIRST_CAN_BIT  = 0;
  localparam int SMALL_RAM_BIT  = 2;

  // one write strobe with its address and data
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] data;
  } xpes_wr_s;
endpackage

// file: xpes_shadow.sv
`timescale 1ns/100ps
// What this block does
// - emulation copy is a write-only register on the on-chip bus at eb7e.
// - peripheral enable word is a readable and writable extended function register.
// - copy keeps enable word layout; bits 5 and 11 to 15 unused.
// - four 16-bit write-only scratch registers reserved for emulator software.
// - enable word ignores writes once global peripheral enable is set.
// - enable word resets to first CAN and small RAM only.
module xpes_shadow
  import xpes_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire xpes_wr_s   bus_wr,
  input  wire logic       pew_wr,
  input  wire logic [15:0] pew_wdata,
  input  wire logic       global_peripheral_enable,
  output logic      [15:0] peripheral_enable_word,
  output logic      [15:0] peripheral_enable_emulation_copy,
  output logic      [15:0] emulation_scratch_zero,
  output logic      [15:0] emulation_scratch_one,
  output logic      [15:0] emulation_scratch_two,
  output logic      [15:0] emulation_scratch_three
);

  function automatic logic hit(input xpes_wr_s w, input logic [15:0] a);
    hit = w.wr && (w.addr == a);
  endfunction

  // enable word layout: unused bits always read back as zero
  function automatic logic [15:0] keep_layout(input logic [15:0] d);
    keep_layout = d & PEW_IMPL_MASK;
  endfunction

  // address decode kept apart for the checks below
  // an unmapped write in the window must leave every register alone
  logic       copy_sel;
  logic [3:0] scratch_sel;
  logic       mapped_sel;

  always_comb
  begin
    copy_sel       = hit(bus_wr, ADDR_EMU_COPY);
    scratch_sel[0] = hit(bus_wr, ADDR_EMU_SCRATCH_ZERO);
    scratch_sel[1] = hit(bus_wr, ADDR_EMU_SCRATCH_ONE);
    scratch_sel[2] = hit(bus_wr, ADDR_EMU_SCRATCH_TWO);
    scratch_sel[3] = hit(bus_wr, ADDR_EMU_SCRATCH_THREE);
    mapped_sel     = copy_sel || (|scratch_sel);
  end

  // enable word: locked once global enable is set, unused bits kept zero
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      peripheral_enable_word <= PEW_RESET;
    else if (pew_wr && !global_peripheral_enable)
      peripheral_enable_word <= pew_wdata & PEW_IMPL_MASK;
  end

  // emulation copy: no reset, content undefined until written
  always_ff @(posedge ref_clk)
  begin
    if (hit(bus_wr, ADDR_EMU_COPY))
      peripheral_enable_emulation_copy <= bus_wr.data & PEW_IMPL_MASK;
  end

  // scratch registers: write only, no read path exists on the bus
  always_ff @(posedge ref_clk)
  begin
    if (hit(bus_wr, ADDR_EMU_SCRATCH_ZERO))
      emulation_scratch_zero <= bus_wr.data;
    if (hit(bus_wr, ADDR_EMU_SCRATCH_ONE))
      emulation_scratch_one <= bus_wr.data;
    if (hit(bus_wr, ADDR_EMU_SCRATCH_TWO))
      emulation_scratch_two <= bus_wr.data;
    if (hit(bus_wr, ADDR_EMU_SCRATCH_THREE))
      emulation_scratch_three <= bus_wr.data;
  end

  chk_copy_takes_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hit(bus_wr, ADDR_EMU_COPY) |=>
      peripheral_enable_emulation_copy == ($past(bus_wr.data) & PEW_IMPL_MASK))
    else $error("copy did not take bus write");
  chk_copy_unused_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hit(bus_wr, ADDR_EMU_COPY) |=> (peripheral_enable_emulation_copy & ~PEW_IMPL_MASK) == 16'h0)
    else $error("unused copy bits set");
  chk_word_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    global_peripheral_enable |=> $stable(peripheral_enable_word))
    else $error("enable word changed after lock");
  chk_word_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pew_wr && !global_peripheral_enable |=>
      peripheral_enable_word == ($past(pew_wdata) & PEW_IMPL_MASK))
    else $error("enable word write lost");
  chk_word_reset: assert property (@(posedge ref_clk)
    $fell(sys_rst) |-> peripheral_enable_word == PEW_RESET)
    else $error("enable word reset value wrong");
  chk_scratch_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hit(bus_wr, ADDR_EMU_SCRATCH_TWO) |=> emulation_scratch_two == $past(bus_wr.data))
    else $error("scratch two write lost");
  chk_scratch_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !hit(bus_wr, ADDR_EMU_SCRATCH_ZERO) |=> $stable(emulation_scratch_zero))
    else $error("scratch zero changed unasked");
  chk_copy_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !hit(bus_wr, ADDR_EMU_COPY) |=> $stable(peripheral_enable_emulation_copy))
    else $error("copy changed unasked");

  // write steps: a strobe on the copy address, then the copy shows the data
  sequence seq_copy_write;
    copy_sel ##1 peripheral_enable_emulation_copy == keep_layout($past(bus_wr.data));
  endsequence

  // write steps: an unlocked word write, then the word shows the data
  sequence seq_word_write;
    (pew_wr && !global_peripheral_enable) ##1
      peripheral_enable_word == keep_layout($past(pew_wdata));
  endsequence

  // copy write built from its steps
  chk_copy_sequence: assert property (@(posedge ref_clk) disable iff (sys_rst)
    copy_sel |-> seq_copy_write)
    else $error("copy write steps broken");

  // word write built from its steps
  chk_word_sequence: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pew_wr && !global_peripheral_enable |-> seq_word_write)
    else $error("word write steps broken");

  // a refused write must leave the word as it was
  chk_word_refused: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pew_wr && global_peripheral_enable |=> $stable(peripheral_enable_word))
    else $error("locked word took a write");

  // the word only moves on its own strobe
  chk_word_idle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pew_wr |=> $stable(peripheral_enable_word))
    else $error("word changed without a write");

  // unused word bits never set, whatever software writes
  chk_word_unused_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (peripheral_enable_word & ~PEW_IMPL_MASK) == 16'h0)
    else $error("unused word bits set");

  // after reset the first controller and the small memory are preselected
  chk_reset_preselect: assert property (@(posedge ref_clk)
    $fell(sys_rst) |->
      peripheral_enable_word[FIRST_CAN_BIT] && peripheral_enable_word[SMALL_RAM_BIT])
    else $error("preselect bits missing after reset");

  // scratch zero takes its write
  chk_scratch_zero_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scratch_sel[0] |=> emulation_scratch_zero == $past(bus_wr.data))
    else $error("scratch zero write lost");

  // scratch one takes its write
  chk_scratch_one_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scratch_sel[1] |=> emulation_scratch_one == $past(bus_wr.data))
    else $error("scratch one write lost");

  // scratch three takes its write
  chk_scratch_three_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scratch_sel[3] |=> emulation_scratch_three == $past(bus_wr.data))
    else $error("scratch three write lost");

  // scratch one only moves on its own address
  chk_scratch_one_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !scratch_sel[1] |=> $stable(emulation_scratch_one))
    else $error("scratch one changed unasked");

  // scratch two only moves on its own address
  chk_scratch_two_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !scratch_sel[2] |=> $stable(emulation_scratch_two))
    else $error("scratch two changed unasked");

  // scratch three only moves on its own address
  chk_scratch_three_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !scratch_sel[3] |=> $stable(emulation_scratch_three))
    else $error("scratch three changed unasked");

  // a scratch write must not alias onto the copy, which the emulator trusts
  chk_copy_no_alias: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|scratch_sel) |=> $stable(peripheral_enable_emulation_copy))
    else $error("scratch write reached copy");

  // a word write alone never refreshes the copy; software must do that itself
  chk_copy_apart: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pew_wr && !copy_sel |=> $stable(peripheral_enable_emulation_copy))
    else $error("copy followed the word");

  // scratch zero write leaves its neighbours alone
  chk_scratch_zero_apart: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scratch_sel[0] |=> $stable(emulation_scratch_one) && $stable(emulation_scratch_three))
    else $error("scratch zero write aliased");

  // scratch three write leaves its neighbours alone
  chk_scratch_three_apart: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scratch_sel[3] |=> $stable(emulation_scratch_zero) && $stable(emulation_scratch_two))
    else $error("scratch three write aliased");

  // writes outside the five addresses are dropped; no decode wraps around
  chk_unmapped_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bus_wr.wr && !mapped_sel |=>
      $stable(peripheral_enable_emulation_copy) && $stable(emulation_scratch_zero)
        && $stable(emulation_scratch_one) && $stable(emulation_scratch_two)
        && $stable(emulation_scratch_three))
    else $error("unmapped write changed a register");

  // unused copy bits stay clear after any copy write, even one of all ones
  chk_copy_layout: assert property (@(posedge ref_clk) disable iff (sys_rst)
    copy_sel |=> peripheral_enable_emulation_copy[15:11] == 5'h0
      && peripheral_enable_emulation_copy[5] == 1'b0)
    else $error("copy layout broken");
endmodule

// file: xpes_emu_model.sv
`timescale 1ns/100ps
module xpes_emu_model
  import xpes_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] copy,
  output logic      [15:0] seen
);
  // emulator latches the final setup; unused bits dropped
  always_ff @(posedge ref_clk)
    seen <= copy & PEW_IMPL_MASK;
endmodule

// file: test_on_chip_peripheral_bus_periph_emulation_shadow.sv
`timescale 1ns/100ps
module test_on_chip_peripheral_bus_periph_emulation_shadow
  import xpes_pkg::*;
;
  logic        ref_clk = 0, sys_rst = 1, pew_wr = 0, gpe = 0;
  logic [15:0] pew_wdata = 0, pew, s0, s1, s2, s3, cp, seen, mp, m [6], o [5];
  logic [15:0] ad [6] = '{ADDR_EMU_SCRATCH_ZERO, ADDR_EMU_SCRATCH_ONE, ADDR_EMU_SCRATCH_TWO,
    ADDR_EMU_SCRATCH_THREE, ADDR_EMU_COPY, 16'heb80};
  logic [31:0] rng = 32'h6fa84ab0;
  int          err_total = 0, total_checks = 0, cyc = 0;
  xpes_wr_s    bus_wr = '0;
  assign o = '{s0, s1, s2, s3, cp};
  xpes_shadow dut_u (.ref_clk, .sys_rst, .bus_wr, .pew_wr, .pew_wdata,
    .global_peripheral_enable(gpe), .peripheral_enable_word(pew),
    .peripheral_enable_emulation_copy(cp), .emulation_scratch_zero(s0),
    .emulation_scratch_one(s1), .emulation_scratch_two(s2), .emulation_scratch_three(s3));
  xpes_emu_model emu_u (.ref_clk, .copy(cp), .seen);
  always #20 ref_clk = ~ref_clk;
  // hang guard, run needs about 100 cycles
  always @(posedge ref_clk)
    if (++cyc == 500)
    begin
      err_total++;
      final_report();
    end
  function automatic logic [31:0] xs(logic [31:0] a);
    a ^= a << 13;
    a ^= a >> 17;
    return a ^ (a << 5);
  endfunction
  task automatic chk(string n, logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // one bus write and, when p is set, one enable word write share the cycle
  task automatic wr(logic [15:0] a, d, logic p, g);
    @(posedge ref_clk) {bus_wr, pew_wr, pew_wdata, gpe} <= {1'b1, a, d, p, d, g};
    @(posedge ref_clk) {bus_wr.wr, pew_wr} <= 2'b00;
    #1;
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // lock rises at i 25 together with a word write, which must be lost
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    mp = PEW_RESET;
    for (int i = 0; i < 36; i++)
    begin
      rng = xs(rng);
      wr(ad[i % 6], rng[15:0], rng[16], i > 24);
      if (rng[16] && i <= 24) mp = rng[15:0] & PEW_IMPL_MASK;
      m[i % 6] = (i % 6 == 4) ? rng[15:0] & PEW_IMPL_MASK : rng[15:0];
      chk("word", mp, pew);
      if (i > 4) foreach (o[k]) chk("reg", m[k], o[k]);
    end
    // software copies only with a peripheral on; otherwise the last copy write stays
    if ((mp & PEW_PERIPH_MSK) != 0)
    begin
      wr(ADDR_EMU_COPY, mp, 1'b1, 1'b1);
      m[4] = mp;
    end
    chk("copy", m[4], cp);
    // the emulator model latches one edge after the copy updates
    @(posedge ref_clk);
    #1;
    chk("seen", m[4], seen);
    final_report();
  end
endmodule
